// ---- hw/bbpd_pkg.sv ----
// Purpose: shared constants and types of the pixel datapath
// Assumes: one clock, both ends on it
// Notes:   control word layout is fixed here for both ends
package bbpd_pkg;
  // ==========================================================
  // widths
  localparam int unsigned BBPD_DATA_W   = 16;
  localparam int unsigned BBPD_DEPTH    = 16;
  localparam int unsigned BBPD_ADDR_W   = 4;
  localparam int unsigned BBPD_FUNC_W   = 4;
  // ==========================================================
  // control word fields
  localparam int unsigned BBPD_CTL_LM_LSB    = 0;
  localparam int unsigned BBPD_CTL_RM_LSB    = 4;
  localparam int unsigned BBPD_CTL_SHIFT_LSB = 8;
  localparam int unsigned BBPD_CTL_SWAP_BIT  = 12;
  localparam int unsigned BBPD_FIELD_W       = 4;
  // ==========================================================
  // reset values
  localparam logic [15:0] BBPD_CTL_RESET  = 16'h0000;
  localparam logic [3:0]  BBPD_FUNC_RESET = 4'h0;
  localparam logic [15:0] BBPD_DATA_RESET = 16'h0000;
  localparam logic [15:0] BBPD_RING_START = 16'h0001;
  // ==========================================================
  // host command set
  typedef enum logic [3:0] {
    BBPD_OP_LOAD_FUNC  = 4'h0,
    BBPD_OP_LOAD_CTRL  = 4'h1,
    BBPD_OP_LOAD_SRC   = 4'h2,
    BBPD_OP_LOAD_DEST  = 4'h3,
    BBPD_OP_QUEUE_WR   = 4'h4,
    BBPD_OP_QUEUE_RD   = 4'h5,
    BBPD_OP_LOAD_PIXEL = 4'h6,
    BBPD_OP_READ_PIXEL = 4'h7,
    BBPD_OP_QUEUE_CLR  = 4'h8,
    BBPD_OP_READ_DATA  = 4'h9
  } bbpd_op_type;
  // ==========================================================
  // host sequencer states
  typedef enum logic [1:0] {
    BBPD_ST_IDLE  = 2'b00,
    BBPD_ST_ISSUE = 2'b01,
    BBPD_ST_READ  = 2'b10,
    BBPD_ST_DONE  = 2'b11
  } bbpd_state_type;
endpackage : bbpd_pkg

// ---- hw/bbpd_if.sv ----
// Purpose: pins between the datapath and its controlling party
// Assumes: all pins on clk_sys, strobes active high
// Notes:   resolves the shared data and pixel wires from enables
`timescale 1ns/100ps
`default_nettype none
interface bbpd_if;
  logic [15:0] data_host;            // host data drive
  logic        data_host_oe;         // host drives data
  logic [15:0] data_dev;             // device data drive
  logic        data_dev_oe;          // device drives data
  logic [15:0] data_wire;            // resolved data port
  logic        data_load_strobe;     // load input master latch
  logic        block_source_select;  // 1 source, 0 destination
  logic        function_load_strobe; // load function code
  logic        control_load_strobe;  // load control word
  logic        queue_write_strobe;   // write queue
  logic        queue_read_strobe;    // read queue
  logic        queue_reset;          // clear queue pointers
  logic        line_mode;            // 1 line, 0 block
  logic        left_mask_enable;     // apply left mask
  logic        right_mask_enable;    // apply right mask
  logic [3:0]  pixel_address;        // pixel bit select
  logic        pixel_load_strobe;    // load pixel input latch
  logic        pixel_output_enable;  // request pixel drive
  logic        data_out_enable;      // request data drive
  logic        pixel_host;           // host pixel drive
  logic        pixel_host_oe;        // host drives pixel
  logic        pixel_dev;            // device pixel drive
  logic        pixel_dev_oe;         // device drives pixel
  logic        pixel_wire;           // resolved pixel port

  // ==========================================================
  // wire resolution
  assign data_wire  = data_dev_oe ? data_dev :
                      (data_host_oe ? data_host : 16'h0000);
  assign pixel_wire = pixel_dev_oe ? pixel_dev :
                      (pixel_host_oe ? pixel_host : 1'b0);

  modport device (
    input  data_wire, data_load_strobe, block_source_select,
           function_load_strobe, control_load_strobe,
           queue_write_strobe, queue_read_strobe, queue_reset,
           line_mode, left_mask_enable, right_mask_enable,
           pixel_address, pixel_load_strobe, pixel_output_enable,
           data_out_enable, pixel_wire,
    output data_dev, data_dev_oe, pixel_dev, pixel_dev_oe
  );
  modport host (
    input  data_wire, pixel_wire,
    output data_host, data_host_oe, data_load_strobe,
           block_source_select, function_load_strobe,
           control_load_strobe, queue_write_strobe,
           queue_read_strobe, queue_reset, line_mode,
           left_mask_enable, right_mask_enable, pixel_address,
           pixel_load_strobe, pixel_output_enable,
           data_out_enable, pixel_host, pixel_host_oe
  );
endinterface : bbpd_if
`default_nettype wire

// ---- hw/bbpd_device.sv ----
// Purpose: shifter, queue, logic/mask unit and pixel port
// Assumes: controlling party drives strobes on clk_sys
// Notes:   queue has no overflow guard; pointers wrap
`timescale 1ns/100ps
`default_nettype none
module bbpd_device
  import bbpd_pkg::*;
#(
  parameter int unsigned DATA_W = BBPD_DATA_W, // word width
  parameter int unsigned DEPTH  = BBPD_DEPTH   // queue depth
) (
  input  wire logic  clk_sys,                  // system clock
  input  wire logic  rst_n,                    // sync reset
  bbpd_if.device     pins,                     // link pins
  output logic [15:0] control_word,            // control readback
  output logic [3:0]  function_code,           // function readback
  output logic [15:0] queue_read_ring,         // read pointer
  output logic [15:0] queue_write_ring         // write pointer
);
  // ==========================================================
  // elaboration checks
  if (DATA_W != 16) begin : g_chk_w
    $error("bbpd_device: word width must be 16");
  end
  if (DEPTH != 16) begin : g_chk_d
    $error("bbpd_device: queue depth must be 16");
  end

  // ==========================================================
  // functions
  // per-bit function code
  function automatic logic [15:0] apply_func(
    input logic [3:0]  f,
    input logic [15:0] s,
    input logic [15:0] d
  );
    apply_func = ({16{f[3]}} & ~s & ~d) | ({16{f[2]}} & ~s & d) |
                 ({16{f[1]}} & s & ~d) | ({16{f[0]}} & s & d);
  endfunction

  function automatic logic [15:0] ring_step(input logic [15:0] r);
    ring_step = {r[14:0], r[15]};
  endfunction

  function automatic logic [3:0] ring_index(input logic [15:0] r);
    ring_index = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (r[k]) begin
        ring_index = k[3:0];
      end
    end
  endfunction

  // ==========================================================
  // state
  logic [15:0] input_master_latch;
  logic        transfer_pend_reg;
  logic        transfer_src_reg;
  logic [15:0] source_input_latch;
  logic [15:0] barrel_pipeline_latch;
  logic [15:0] destination_input_latch;
  logic [15:0] control_reg;
  logic [3:0]  function_code_reg;
  logic [15:0] read_ring_reg;
  logic [15:0] write_ring_reg;
  logic [15:0] queue_mem [DEPTH];
  logic        pixel_in_latch;
  logic        pixel_out_latch;
  logic [15:0] data_out_reg;

  logic [3:0]  left_mask_field;
  logic [3:0]  right_mask_field;
  logic [3:0]  shift_count;
  logic        word_swap;
  logic [15:0] upper_word;
  logic [15:0] lower_word;
  logic [31:0] shifter_in;
  logic [15:0] shifter_out;
  logic [15:0] queue_head;
  logic [15:0] block_enable;
  logic [15:0] block_result;
  logic [15:0] line_enable;
  logic [15:0] line_result;

  assign left_mask_field  = control_reg[BBPD_CTL_LM_LSB +: BBPD_FIELD_W];
  assign right_mask_field = control_reg[BBPD_CTL_RM_LSB +: BBPD_FIELD_W];
  assign shift_count  = control_reg[BBPD_CTL_SHIFT_LSB +: BBPD_FIELD_W];
  assign word_swap    = control_reg[BBPD_CTL_SWAP_BIT];

  // ==========================================================
  // control and function registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_reg <= BBPD_CTL_RESET;
    end else if (pins.control_load_strobe) begin
      control_reg <= pins.data_wire;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      function_code_reg <= BBPD_FUNC_RESET;
    end else if (pins.function_load_strobe) begin
      function_code_reg <= pins.data_wire[3:0];
    end
  end

  // ==========================================================
  // input latches
  // capture into master, note routing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      input_master_latch <= BBPD_DATA_RESET;
      transfer_pend_reg  <= 1'b0;
      transfer_src_reg   <= 1'b0;
    end else begin
      transfer_pend_reg <= pins.data_load_strobe;
      if (pins.data_load_strobe) begin
        input_master_latch <= pins.data_wire;
        transfer_src_reg   <= pins.block_source_select;
      end
    end
  end

  // first word moves on as second lands
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      source_input_latch    <= BBPD_DATA_RESET;
      barrel_pipeline_latch <= BBPD_DATA_RESET;
    end else if (transfer_pend_reg && transfer_src_reg) begin
      source_input_latch    <= input_master_latch;
      barrel_pipeline_latch <= source_input_latch;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      destination_input_latch <= BBPD_DATA_RESET;
    end else if (transfer_pend_reg && !transfer_src_reg) begin
      destination_input_latch <= input_master_latch;
    end
  end

  // ==========================================================
  // swap mux and barrel shifter
  // whole-word swap only
  assign upper_word = word_swap ? source_input_latch : barrel_pipeline_latch;
  assign lower_word = word_swap ? barrel_pipeline_latch : source_input_latch;
  assign shifter_in = {lower_word, upper_word};
  // bit j from upper j+i or lower j+i-16
  assign shifter_out = 16'(shifter_in >> shift_count);

  // ==========================================================
  // queue
  // reset pin homes both rings
  always_ff @(posedge clk_sys) begin
    if (!rst_n || pins.queue_reset) begin
      write_ring_reg <= BBPD_RING_START;
    end else if (pins.queue_write_strobe) begin
      write_ring_reg <= ring_step(write_ring_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || pins.queue_reset) begin
      read_ring_reg <= BBPD_RING_START;
    end else if (pins.queue_read_strobe) begin
      read_ring_reg <= ring_step(read_ring_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (pins.queue_write_strobe) begin
      queue_mem[ring_index(write_ring_reg)] <= shifter_out;
    end
  end

  assign queue_head = queue_mem[ring_index(read_ring_reg)];

  // ==========================================================
  // logic and mask unit
  // left/right masks gated by enables
  always_comb begin
    block_enable = 16'hFFFF;
    for (int j = 0; j < 16; j++) begin
      if (pins.left_mask_enable && (j[3:0] < left_mask_field)) begin
        block_enable[j] = 1'b0;
      end
      if (pins.right_mask_enable && (j[3:0] > right_mask_field)) begin
        block_enable[j] = 1'b0;
      end
    end
  end

  assign block_result =
    (apply_func(function_code_reg, queue_head, destination_input_latch)
     & block_enable) | (destination_input_latch & ~block_enable);

  assign line_enable = 16'(16'h0001 << pins.pixel_address);
  assign line_result =
    (apply_func(function_code_reg, {16{pixel_in_latch}},
                destination_input_latch) & line_enable) |
    (destination_input_latch & ~line_enable);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out_reg <= BBPD_DATA_RESET;
    end else if (pins.line_mode) begin
      data_out_reg <= line_result;
    end else if (pins.queue_read_strobe) begin
      data_out_reg <= block_result;
    end
  end

  // ==========================================================
  // pixel port
  // capture while load strobe high
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pixel_in_latch <= 1'b0;
    end else if (pins.pixel_load_strobe) begin
      pixel_in_latch <= pins.pixel_wire;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pixel_out_latch <= 1'b0;
    end else begin
      pixel_out_latch <= destination_input_latch[pins.pixel_address];
    end
  end

  // ==========================================================
  // pin drive
  // drive pixel only on enable
  assign pins.pixel_dev    = pixel_out_latch;
  assign pins.pixel_dev_oe = pins.pixel_output_enable;
  assign pins.data_dev     = data_out_reg;
  assign pins.data_dev_oe  = pins.data_out_enable;

  assign control_word     = control_reg;
  assign function_code    = function_code_reg;
  assign queue_read_ring  = read_ring_reg;
  assign queue_write_ring = write_ring_reg;
endmodule : bbpd_device
`default_nettype wire

// ---- hw/bbpd_host.sv ----
// Purpose: controlling end turning commands into pin strobes
// Assumes: one command at a time, cmd_ready handshake
// Notes:   reads return one word on rsp_valid
`timescale 1ns/100ps
`default_nettype none
module bbpd_host
  import bbpd_pkg::*;
(
  input  wire logic        clk_sys,         // system clock
  input  wire logic        rst_n,           // sync reset
  bbpd_if.host             pins,            // link pins
  input  wire logic        cmd_valid,       // command request
  output logic             cmd_ready,       // command accepted
  input  wire bbpd_op_type cmd_op,          // command code
  input  wire logic [15:0] cmd_data,        // command data
  input  wire logic        right_to_left,   // fetch direction
  input  wire logic        line_request,    // want line mode
  input  wire logic        left_mask_on,    // left mask request
  input  wire logic        right_mask_on,   // right mask request
  input  wire logic [3:0]  pixel_addr_in,   // pixel address
  output logic             rsp_valid,       // read answer pulse
  output logic [15:0]      rsp_data,        // read answer
  output logic             pixel_loaded     // pixel latch loaded
);
  bbpd_state_type state_reg;
  bbpd_op_type    op_reg;
  logic [15:0]    data_reg;
  logic           pixel_loaded_reg;
  logic           rsp_valid_reg;
  logic [15:0]    rsp_data_reg;
  logic           issue;
  logic           reading;

  assign cmd_ready = (state_reg == BBPD_ST_IDLE);
  assign issue     = (state_reg == BBPD_ST_ISSUE);
  assign reading   = (state_reg == BBPD_ST_READ);

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= BBPD_ST_IDLE;
      op_reg    <= BBPD_OP_LOAD_FUNC;
      data_reg  <= BBPD_DATA_RESET;
    end else begin
      case (state_reg)
        BBPD_ST_IDLE: begin
          if (cmd_valid) begin
            op_reg    <= cmd_op;
            data_reg  <= cmd_data;
            state_reg <= BBPD_ST_ISSUE;
            if (cmd_op == BBPD_OP_LOAD_CTRL) begin
              data_reg[BBPD_CTL_SWAP_BIT] <= right_to_left;
            end
          end
        end
        BBPD_ST_ISSUE: begin
          if (op_reg == BBPD_OP_QUEUE_RD || op_reg == BBPD_OP_READ_PIXEL ||
              op_reg == BBPD_OP_READ_DATA) begin
            state_reg <= BBPD_ST_READ;
          end else begin
            state_reg <= BBPD_ST_DONE;
          end
        end
        BBPD_ST_READ: state_reg <= BBPD_ST_DONE;
        BBPD_ST_DONE: state_reg <= BBPD_ST_IDLE;
        default:      state_reg <= BBPD_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // answers and pixel tracking
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= BBPD_DATA_RESET;
    end else begin
      rsp_valid_reg <= reading;
      if (reading) begin
        rsp_data_reg <= (op_reg == BBPD_OP_READ_PIXEL) ?
                        {15'h0000, pins.pixel_wire} : pins.data_wire;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pixel_loaded_reg <= 1'b0;
    end else if (issue && op_reg == BBPD_OP_LOAD_PIXEL) begin
      pixel_loaded_reg <= 1'b1;
    end
  end

  // ==========================================================
  // pin drive
  assign pins.data_host            = data_reg;
  assign pins.data_host_oe         = issue &&
                                     (op_reg == BBPD_OP_LOAD_FUNC ||
                                      op_reg == BBPD_OP_LOAD_CTRL ||
                                      op_reg == BBPD_OP_LOAD_SRC ||
                                      op_reg == BBPD_OP_LOAD_DEST);
  assign pins.function_load_strobe = issue && op_reg == BBPD_OP_LOAD_FUNC;
  assign pins.control_load_strobe  = issue && op_reg == BBPD_OP_LOAD_CTRL;
  assign pins.data_load_strobe     = issue &&
                                     (op_reg == BBPD_OP_LOAD_SRC ||
                                      op_reg == BBPD_OP_LOAD_DEST);
  assign pins.block_source_select  = (op_reg == BBPD_OP_LOAD_SRC);
  assign pins.queue_write_strobe   = issue && op_reg == BBPD_OP_QUEUE_WR;
  assign pins.queue_read_strobe    = issue && op_reg == BBPD_OP_QUEUE_RD;
  assign pins.queue_reset          = issue && op_reg == BBPD_OP_QUEUE_CLR;
  assign pins.pixel_load_strobe    = issue && op_reg == BBPD_OP_LOAD_PIXEL;
  assign pins.pixel_host           = data_reg[0];
  assign pins.pixel_host_oe        = issue && op_reg == BBPD_OP_LOAD_PIXEL;
  assign pins.pixel_output_enable  = reading && op_reg == BBPD_OP_READ_PIXEL;
  assign pins.data_out_enable      = reading && op_reg != BBPD_OP_READ_PIXEL;
  // line mode only after pixel load
  assign pins.line_mode            = line_request && pixel_loaded_reg;
  assign pins.left_mask_enable     = left_mask_on;
  assign pins.right_mask_enable    = right_mask_on;
  assign pins.pixel_address        = pixel_addr_in;

  assign rsp_valid    = rsp_valid_reg;
  assign rsp_data     = rsp_data_reg;
  assign pixel_loaded = pixel_loaded_reg;
endmodule : bbpd_host
`default_nettype wire

// ---- verif/bbpd_chk.sv ----
// Purpose: wire checks between host and device ends
// Assumes: every signal on clk_sys
// Notes:   one command in flight at a time
`timescale 1ns/100ps
`default_nettype none
module bbpd_chk (
  input wire logic clk_sys,             // system clock
  input wire logic rst_n,               // sync reset
  input wire logic data_dev_oe,         // device data drive
  input wire logic data_out_enable,     // data drive request
  input wire logic pixel_dev_oe,        // device pixel drive
  input wire logic pixel_output_enable, // pixel drive request
  input wire logic data_load_strobe,    // master latch load
  input wire logic queue_write_strobe,  // queue write
  input wire logic queue_read_strobe,   // queue read
  input wire logic line_mode,           // line or block
  input wire logic pixel_load_strobe    // pixel latch load
);
  // ==========================================================
  // helper
  logic pix_seen_reg; // pixel latch written since reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pix_seen_reg <= 1'b0;
    end else if (pixel_load_strobe) begin
      pix_seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // checks
  a_pix_drive_gate: assert property
    (pixel_dev_oe == pixel_output_enable) else $error("pixel drive");
  a_data_drive_gate: assert property
    (data_dev_oe == data_out_enable) else $error("data drive");
  a_load_spacing: assert property
    (data_load_strobe |=> !data_load_strobe [*2]) else $error("dls");
  a_qwr_single: assert property
    (queue_write_strobe |=> !queue_write_strobe ##1 !queue_write_strobe)
    else $error("qwr pulse");
  a_qwr_alone: assert property
    (queue_write_strobe |-> !queue_read_strobe && !data_load_strobe)
    else $error("qwr overlap");
  a_qrd_single: assert property
    ($rose(queue_read_strobe) |=> !queue_read_strobe) else $error("qrd");
  a_qrd_presents: assert property
    (queue_read_strobe |=> data_out_enable) else $error("no present");
  a_drive_release: assert property
    (data_out_enable |-> ##[1:4] !data_out_enable) else $error("oe held");
  a_line_after_pix: assert property
    (line_mode |-> pix_seen_reg || pixel_load_strobe) else $error("line");
endmodule // bbpd_chk
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: drives both ends through the host user side
// Assumes: host and device joined by one interface
// Notes:   read expectations queued by the driver
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bbpd_pkg::*;
  logic        clk_sys, rst_n, cmd_valid, cmd_ready, rsp_valid, pixel_loaded;
  logic        right_to_left, line_request, left_mask_on, right_mask_on;
  logic [3:0]  pixel_addr_in, function_code;
  logic [15:0] cmd_data, rsp_data, control_word, rd_ring, wr_ring;
  logic [15:0] seed_reg, w1, w2, dst, ctl, hi, lo, s, en;
  bbpd_op_type cmd_op;
  logic [31:0] exp_q[$];
  int          n_mismatch, cmp_count, cyc;
  bbpd_if pins_if();
  bbpd_device bbpd_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .pins(pins_if), .control_word(control_word),
    .function_code(function_code), .queue_read_ring(rd_ring),
    .queue_write_ring(wr_ring));
  bbpd_host bbpd_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .pins(pins_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .right_to_left(right_to_left),
    .line_request(line_request), .left_mask_on(left_mask_on),
    .right_mask_on(right_mask_on), .pixel_addr_in(pixel_addr_in),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pixel_loaded(pixel_loaded));
  bbpd_chk chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .data_dev_oe(pins_if.data_dev_oe),
    .data_out_enable(pins_if.data_out_enable),
    .pixel_dev_oe(pins_if.pixel_dev_oe),
    .pixel_output_enable(pins_if.pixel_output_enable),
    .data_load_strobe(pins_if.data_load_strobe),
    .queue_write_strobe(pins_if.queue_write_strobe),
    .queue_read_strobe(pins_if.queue_read_strobe),
    .line_mode(pins_if.line_mode),
    .pixel_load_strobe(pins_if.pixel_load_strobe));
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] rop(input logic [3:0] f,
                                      input logic [15:0] a, d);
    return ({16{f[3]}} & ~a & ~d) | ({16{f[2]}} & ~a & d) |
           ({16{f[1]}} & a & ~d) | ({16{f[0]}} & a & d);
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmd(input bbpd_op_type op, input logic [15:0] d);
    @(posedge clk_sys) #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    while (cmd_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    cmd_valid = 1'b0;
  endtask
  // read: note mask and value, wait for the answer
  task automatic rd(input bbpd_op_type op, input logic [15:0] m, v);
    exp_q.push_back({m, v});
    cmd(op, 16'h0000);
    while (exp_q.size() != 0) @(posedge clk_sys) #1;
  endtask
  // ==========================================================
  // clock, watchdog, answer monitor
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // answers looked at mid-cycle, where they have settled
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (rsp_valid === 1'b1) begin
      chk("rsp", rsp_data & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, cmd_valid, right_to_left, line_request} = 4'h0;
    {left_mask_on, right_mask_on, pixel_addr_in} = 6'h00;
    {cmd_data, seed_reg} = {16'h0000, 16'h0015};
    cmd_op = BBPD_OP_LOAD_FUNC;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("wr_ring", wr_ring, 16'h0001);
    for (int k = 0; k < 16; k++) begin
      w1 = lfsr(seed_reg);
      w2 = lfsr(w1);
      dst = lfsr(w2);
      ctl = lfsr(dst);
      seed_reg = ctl;
      {right_to_left, left_mask_on, right_mask_on} = ctl[15:13];
      pixel_addr_in = w1[3:0];
      cmd(BBPD_OP_LOAD_FUNC, 16'(k));
      cmd(BBPD_OP_LOAD_CTRL, ctl);
      cmd(BBPD_OP_LOAD_DEST, dst);
      chk("func", {12'h000, function_code}, 16'(k));
      chk("ctl", control_word, {ctl[15:13], ctl[15], ctl[11:0]});
      chk("rings", rd_ring, wr_ring);
      chk("moved", 16'(wr_ring === 16'h0001), 16'(k == 0));
      cmd(BBPD_OP_LOAD_SRC, w1);
      cmd(BBPD_OP_LOAD_SRC, w2);
      cmd(BBPD_OP_QUEUE_WR, 16'h0000);
      {hi, lo} = ctl[15] ? {w2, w1} : {w1, w2};
      s = 16'({lo, hi} >> ctl[11:8]);
      en = 16'hffff;
      for (int j = 0; j < 16; j++) begin
        if ((ctl[14] && j < ctl[3:0]) || (ctl[13] && j > ctl[7:4])) begin
          en[j] = 1'b0;
        end
      end
      rd(BBPD_OP_QUEUE_RD, 16'hffff,
         (rop(4'(k), s, dst) & en) | (dst & ~en));
      line_request = 1'b1;
      cmd(BBPD_OP_LOAD_PIXEL, {15'h0000, w2[5]});
      cmd(BBPD_OP_LOAD_DEST, dst);
      rd(BBPD_OP_READ_PIXEL, 16'h0001, {15'h0000, dst[w1[3:0]]});
      en = 16'h0001 << w1[3:0];
      s = {16{w2[5]}};
      rd(BBPD_OP_READ_DATA, 16'hffff,
         (rop(4'(k), s, dst) & en) | (dst & ~en));
      line_request = 1'b0;
      $display("test %0d done", k);
    end
    chk("wrap", wr_ring, 16'h0001);
    chk("pix_seen", {15'h0000, pixel_loaded}, 16'h0001);
    // move both rings off home before clearing them
    cmd(BBPD_OP_QUEUE_WR, 16'h0000);
    rd(BBPD_OP_QUEUE_RD, 16'h0000, 16'h0000);
    chk("rd_moved", rd_ring, 16'h0002);
    cmd(BBPD_OP_QUEUE_CLR, 16'h0000);
    cmd(BBPD_OP_LOAD_FUNC, 16'h0000);
    chk("clr_wr", wr_ring, 16'h0001);
    chk("clr_rd", rd_ring, 16'h0001);
    $display("test clear done");
    // mid-run reset with the write ring moved
    cmd(BBPD_OP_QUEUE_WR, 16'h0000);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("wr_moved", wr_ring, 16'h0002);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("rst_wr", wr_ring, 16'h0001);
    chk("rst_pix", {15'h0000, pixel_loaded}, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
